// [common/lsw_pkg.sv]
// Shared constants, carrier structs and state types for the low-side switch control block.
// Assumes a single 100 MHz core clock; all time figures are converted to cycles here.
package lsw_pkg;

  // ----------------------------------------------------------------
  // Sizes and bit positions
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int NUM_SER_CH = 6;
  localparam int CMD_W = 8;
  localparam int OPEN_EN_LO_BIT = 6;
  localparam int OPEN_EN_HI_BIT = 7;
  localparam int OPEN_EN_SPLIT_CH = 3;

  // ----------------------------------------------------------------
  // Reset values and frame length
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_READ = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  typedef logic [17:0] cnt_t;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SS_US = 20;
  localparam int T_MASK_US = 10;
  localparam int T_REFRESH_US = 2000;
  localparam cnt_t SS_CYC = cnt_t'((T_SS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t MASK_CYC = cnt_t'((T_MASK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t REFRESH_CYC_DFLT =
    cnt_t'((T_REFRESH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic small_in_b;
    logic small_in_a;
    logic par_in_ch5;
    logic par_in_ch4;
    logic par_in_ch3;
    logic par_in_ch2;
    logic par_in_ch1;
    logic par_in_ch0;
  } par_in_s;

  typedef struct packed {
    logic small_sw_out_b;
    logic small_sw_out_a;
    logic sw_out_ch5;
    logic sw_out_ch4;
    logic sw_out_ch3;
    logic sw_out_ch2;
    logic sw_out_ch1;
    logic sw_out_ch0;
  } sw_out_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
    logic par_mode;
    logic global_short;
    par_in_s par;
    logic [7:0] cur_lim;
    logic [7:0] open_det;
  } pin_in_s;

  localparam int PIN_W = $bits(pin_in_s);
  localparam pin_in_s PIN_IDLE = pin_in_s'({1'b0, 1'b1, {(PIN_W - 2){1'b0}}});

  typedef enum logic [1:0] {CH_OFF, CH_ON, CH_LIMIT, CH_RETRY} ch_state_e;

endpackage : lsw_pkg

// [rtl/lsw_channel.sv]
// One switch channel: current-limit sense, retry duty cycle and open-load masking.
// Assumes cur_lim and open_det are already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
module lsw_channel #(
  parameter lsw_pkg::cnt_t REFRESH_CYC = lsw_pkg::REFRESH_CYC_DFLT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic on_req,
  input wire logic cur_lim,
  input wire logic open_det,
  input wire logic open_on_en,
  output logic drive,
  output logic fault_now
);
  import lsw_pkg::*;

  ch_state_e state_r;
  cnt_t sense_cnt_r;
  cnt_t open_cnt_r;
  logic short_r;
  logic open_flt_r;
  logic open_cond;

  // ----------------------------------------------------------------
  // Switch state and retry timing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CH_OFF;
      sense_cnt_r <= '0;
    end else if (!on_req) begin
      state_r <= CH_OFF;
      sense_cnt_r <= '0;
    end else begin
      case (state_r)
        CH_OFF: begin
          state_r <= CH_ON;
          sense_cnt_r <= '0;
        end
        CH_ON: begin
          if (cur_lim) begin
            state_r <= CH_LIMIT;
          end
          sense_cnt_r <= '0;
        end
        CH_LIMIT: begin
          if (!cur_lim) begin
            state_r <= CH_ON;
            sense_cnt_r <= '0;
          end else if (sense_cnt_r == SS_CYC - 1) begin
            state_r <= CH_RETRY;
            sense_cnt_r <= '0;
          end else begin
            sense_cnt_r <= sense_cnt_r + 1'b1;
          end
        end
        CH_RETRY: begin
          if (sense_cnt_r == REFRESH_CYC - 1) begin
            state_r <= CH_ON;
            sense_cnt_r <= '0;
          end else begin
            sense_cnt_r <= sense_cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= CH_OFF;
          sense_cnt_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault levels
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      short_r <= 1'b0;
    end else if (state_r == CH_LIMIT && cur_lim && sense_cnt_r == SS_CYC - 1) begin
      short_r <= on_req;
    end else if (!on_req || (state_r == CH_ON && !cur_lim)) begin
      short_r <= 1'b0;
    end
  end

  assign open_cond = open_det && (!on_req || open_on_en);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      open_cnt_r <= '0;
      open_flt_r <= 1'b0;
    end else if (!open_cond) begin
      open_cnt_r <= '0;
      open_flt_r <= 1'b0;
    end else if (open_cnt_r == MASK_CYC - 1) begin
      open_flt_r <= 1'b1;
    end else begin
      open_cnt_r <= open_cnt_r + 1'b1;
    end
  end

  assign drive = (state_r == CH_ON) || (state_r == CH_LIMIT);
  assign fault_now = short_r || open_flt_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking ch_cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  short_trip_a: assert property ((state_r == CH_LIMIT && cur_lim && on_req &&
    sense_cnt_r == SS_CYC - 1) |=> (state_r == CH_RETRY && short_r && !drive))
    else $error("short sense time did not end in retry");
  cmd_off_a: assert property (!on_req |=> !drive)
    else $error("channel stayed on after command off");
  open_mask_a: assert property ($rose(open_flt_r) |-> $past(open_cnt_r) == MASK_CYC - 1)
    else $error("open fault flagged before mask time");
  retry_resume_a: assert property ((state_r == CH_RETRY && on_req &&
    sense_cnt_r == REFRESH_CYC - 1) |=> drive)
    else $error("channel did not retry after refresh time");
  retry_c: cover property (state_r == CH_LIMIT ##1 state_r == CH_RETRY);

endmodule : lsw_channel
`default_nettype wire

// [rtl/lsw_ctrl.sv]
// Serial and parallel control of a six plus two channel low-side switch, with fault register.
// Assumes all pins are asynchronous to core_clk and are double-synchronised here; SCLK is
// sampled well above its own rate. The so pin wire is resolved outside from so_o and so_oe.
`timescale 1ns/1ps
`default_nettype none
module lsw_ctrl #(
  parameter lsw_pkg::cnt_t REFRESH_CYC = lsw_pkg::REFRESH_CYC_DFLT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire lsw_pkg::pin_in_s pins,
  output logic so_o,
  output logic so_oe,
  output lsw_pkg::sw_out_s sw_out,
  output logic [7:0] fault_status,
  output logic [7:0] cmd_latched
);
  import lsw_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  pin_in_s meta_r;
  pin_in_s pin_r;
  logic sclk_d_r;
  logic cs_n_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= PIN_IDLE;
      pin_r <= PIN_IDLE;
    end else begin
      meta_r <= pins;
      pin_r <= meta_r;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= pin_r.sclk;
      cs_n_d_r <= pin_r.cs_n;
    end
  end

  // Edges appear in the same cycle the synchronised level moves
  assign sclk_rise = pin_r.sclk && !sclk_d_r;
  assign sclk_fall = !pin_r.sclk && sclk_d_r;
  assign cs_fall = !pin_r.cs_n && cs_n_d_r;
  assign cs_rise = pin_r.cs_n && !cs_n_d_r;
  assign selected = !pin_r.cs_n;

  // ----------------------------------------------------------------
  // Serial shift path
  // ----------------------------------------------------------------
  logic [7:0] shift_r;
  logic [7:0] fault_r;
  logic [7:0] cmd_r;
  logic [3:0] bit_cnt_r;
  logic so_r;
  logic read_done;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= CMD_RESET;
    end else if (cs_fall) begin
      shift_r <= fault_r;
    end else if (selected && sclk_rise) begin
      shift_r <= {shift_r[6:0], pin_r.si};
    end
  end

  // Outgoing bit changes on falling SCLK so the next stage samples it stable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      so_r <= 1'b0;
    end else if (cs_fall) begin
      so_r <= fault_r[7];
    end else if (selected && sclk_fall) begin
      so_r <= shift_r[7];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r <= '0;
    end else if (cs_fall) begin
      bit_cnt_r <= '0;
    end else if (selected && sclk_rise && bit_cnt_r != BITS_PER_READ) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  assign read_done = (bit_cnt_r == BITS_PER_READ);

  // Last eight bits received become the command, even in parallel mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= CMD_RESET;
    end else if (cs_rise) begin
      cmd_r <= shift_r;
    end
  end

  assign so_o = so_r;
  assign so_oe = selected && !pin_r.par_mode;

  // ----------------------------------------------------------------
  // Fault register
  // ----------------------------------------------------------------
  logic [7:0] fault_now;

  // New faults win over the clear at the end of a read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_r <= FAULT_RESET;
    end else if (cs_rise) begin
      fault_r <= fault_now | (read_done ? 8'h00 : fault_r);
    end else if (!selected) begin
      fault_r <= fault_r | fault_now;
    end
  end

  // ----------------------------------------------------------------
  // Channel requests
  // ----------------------------------------------------------------
  logic [7:0] on_req;
  logic [7:0] par_v;
  logic [7:0] open_on_en;
  logic [7:0] drive;

  assign par_v = pin_r.par;

  always_comb begin
    on_req = 8'h00;
    if (pin_r.global_short) begin
      on_req = 8'h00;
    end else if (pin_r.par_mode) begin
      for (int k = 0; k < NUM_SER_CH / 2; k++) begin
        on_req[2 * k] = par_v[2 * k] && par_v[2 * k + 1];
        on_req[2 * k + 1] = par_v[2 * k] && par_v[2 * k + 1];
      end
    end else begin
      on_req[NUM_SER_CH - 1:0] = cmd_r[NUM_SER_CH - 1:0] | par_v[NUM_SER_CH - 1:0];
      on_req[NUM_CH - 1:NUM_SER_CH] = par_v[NUM_CH - 1:NUM_SER_CH];
    end
  end

  always_comb begin
    open_on_en = 8'h00;
    for (int c = 0; c < NUM_SER_CH; c++) begin
      open_on_en[c] = (c < OPEN_EN_SPLIT_CH) ? cmd_r[OPEN_EN_LO_BIT]
        : cmd_r[OPEN_EN_HI_BIT];
    end
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      lsw_channel #(
        .REFRESH_CYC(REFRESH_CYC)
      ) u_ch (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .on_req(on_req[g]),
        .cur_lim(pin_r.cur_lim[g]),
        .open_det(pin_r.open_det[g]),
        .open_on_en(open_on_en[g]),
        .drive(drive[g]),
        .fault_now(fault_now[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [7:0] sw_out_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_out_r <= 8'h00;
    end else if (pin_r.global_short) begin
      sw_out_r <= 8'h00;
    end else begin
      sw_out_r <= drive;
    end
  end

  assign sw_out = sw_out_s'(sw_out_r);
  assign fault_status = fault_r;
  assign cmd_latched = cmd_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking top_cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  mode_tristate_a: assert property (pin_r.par_mode |-> !so_oe)
    else $error("serial output driven in parallel mode");
  idle_tristate_a: assert property (cs_rise |-> !so_oe)
    else $error("serial output driven after chip select rose");
  shift_capture_a: assert property ((selected && sclk_rise && !cs_fall) |=>
    shift_r[0] == $past(pin_r.si))
    else $error("serial input bit not captured on rising clock");
  status_load_a: assert property (cs_fall |=> (shift_r == $past(fault_r) &&
    so_r == $past(fault_r[7])))
    else $error("fault byte not loaded at chip select fall");
  fault_freeze_a: assert property ((selected && $past(selected)) |-> $stable(fault_r))
    else $error("fault register changed during transfer");
  cmd_load_a: assert property (cs_rise |=> cmd_r == $past(shift_r))
    else $error("command not loaded at chip select rise");
  fault_hold_a: assert property ((!selected && !cs_rise) |=>
    ((fault_r & $past(fault_r)) == $past(fault_r)))
    else $error("fault bit cleared without a read");
  pair_ctrl_a: assert property ((pin_r.par_mode && !pin_r.global_short) |->
    (on_req[1:0] == {2{par_v[0] && par_v[1]}} && on_req[7:6] == 2'b00))
    else $error("parallel pair control wrong");
  or_ctrl_a: assert property ((!pin_r.par_mode && !pin_r.global_short) |->
    on_req[5:0] == (cmd_r[5:0] | par_v[5:0]))
    else $error("serial and parallel control not combined");
  shutdown_a: assert property (pin_r.global_short |=> sw_out_r == 8'h00)
    else $error("outputs on during global shutdown");

  // ----------------------------------------------------------------
  // Shift path checks
  // ----------------------------------------------------------------
  so_shift_a: assert property ((selected && sclk_fall && !cs_fall) |=>
    so_r == $past(shift_r[7]))
    else $error("serial output bit not taken from shift register");
  so_steady_a: assert property ((selected && !sclk_fall && !cs_fall) |=>
    $stable(so_r))
    else $error("serial output moved without a falling clock");
  bit_clear_a: assert property (cs_fall |=> bit_cnt_r == 4'h0)
    else $error("bit count not cleared at chip select fall");
  bit_count_a: assert property ((selected && sclk_rise && !cs_fall && !read_done) |=>
    bit_cnt_r == $past(bit_cnt_r) + 4'h1)
    else $error("rising serial clock not counted");
  shift_hold_a: assert property (!selected |=> $stable(shift_r))
    else $error("shift register moved while deselected");
  so_hold_a: assert property (!selected |=> $stable(so_r))
    else $error("serial output bit moved while deselected");

  // ----------------------------------------------------------------
  // Fault and output checks
  // ----------------------------------------------------------------
  fault_read_a: assert property ((cs_rise && read_done) |=>
    fault_r == $past(fault_now))
    else $error("fault bits not cleared after a read");
  fault_keep_a: assert property ((cs_rise && !read_done) |=>
    ((fault_r & $past(fault_r)) == $past(fault_r)))
    else $error("fault bits cleared by a short frame");
  cmd_stable_a: assert property (!cs_rise |=> $stable(cmd_r))
    else $error("command register changed outside chip select rise");
  mode_pairs_a: assert property ((pin_r.par_mode && !pin_r.global_short) |->
    (on_req[3:2] == {2{par_v[2] && par_v[3]}} && on_req[5:4] == {2{par_v[4] && par_v[5]}}))
    else $error("upper parallel pairs not controlled by their pins");
  out_follow_a: assert property (!pin_r.global_short |=>
    sw_out_r == $past(drive))
    else $error("switch outputs do not follow channel drive");
  shutdown_req_a: assert property (pin_r.global_short |-> on_req == 8'h00)
    else $error("channel request raised during global shutdown");

  read_c: cover property (cs_fall ##[1:1000] (cs_rise && read_done));
  mode_c: cover property ($rose(pin_r.par_mode) ##[1:1000] cs_rise);
  fault_c: cover property ($rose(fault_r[0]));
  shutdown_c: cover property ($rose(pin_r.global_short));

endmodule : lsw_ctrl
`default_nettype wire

// [tb/spi_host_model.sv]
// Host side of the serial link: drives chip select, serial clock and data, reads the reply.
// Assumes the caller resolves the reply line, pull-up included, before it reaches miso.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int HALF_NS = 40
) (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic sel();
    cs_n = 1'b0;
    #(HALF_NS);
  endtask : sel

  // MSB first, data set while clock low, reply read at each rising edge
  task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      #(HALF_NS);
      q[i] = miso;
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
    end
  endtask : shift

  // Clock stays low between frames; data falls back to its pull-down level
  task automatic desel();
    cs_n = 1'b1;
    si = 1'b0;
    #(2 * HALF_NS);
  endtask : desel
endmodule : spi_host_model
`default_nettype wire

// [tb/lsw_ctrl_tb.sv]
// Self-checking bench for the switch control block, one scenario per task.
// Assumes a second instance sits behind the first for chained frames.
`timescale 1ns/1ps
`default_nettype none
module lsw_ctrl_tb;
  import lsw_pkg::*;
  localparam cnt_t RCYC = 18'h32;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, si, o1, oe1, o2, oe2, so1, so2;
  logic mode = 1'b0;
  logic gshort = 1'b0;
  logic chain = 1'b0;
  logic [7:0] par = 8'h00;
  logic [7:0] clim = 8'h00;
  logic [7:0] odet = 8'h00;
  logic [7:0] f1, c1, c2;
  logic [31:0] q;
  sw_out_s sw1;
  pin_in_s p1, p2;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 core_clk = ~core_clk;
  // Pull-up on each reply line
  assign so1 = oe1 ? o1 : 1'b1;
  assign so2 = oe2 ? o2 : 1'b1;
  assign p1 = {sclk, cs_n, si, mode, gshort, par, clim, odet};
  assign p2 = {sclk, cs_n | ~chain, so1, mode, gshort, par, 8'h00, 8'h00};

  spi_host_model HOST (.sclk(sclk), .cs_n(cs_n), .si(si), .miso(chain ? so2 : so1));
  lsw_ctrl #(.REFRESH_CYC(RCYC)) DUT (.core_clk(core_clk), .reset_n(reset_n), .pins(p1),
    .so_o(o1), .so_oe(oe1), .sw_out(sw1), .fault_status(f1), .cmd_latched(c1));
  lsw_ctrl #(.REFRESH_CYC(RCYC)) DUT2 (.core_clk(core_clk), .reset_n(reset_n), .pins(p2),
    .so_o(o2), .so_oe(oe2), .sw_out(), .fault_status(), .cmd_latched(c2));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wcyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wcyc

  task automatic xfer(input int n, input logic [31:0] d);
    HOST.sel();
    HOST.shift(n, d, q);
    HOST.desel();
    wcyc(8);
  endtask : xfer

  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("cmd", c1, 32'h0);
    check("fault", f1, 32'h0);
    check("out", sw1, 32'h0);
    check("oe", oe1, 32'h0);
  endtask : t_reset

  task automatic t_serial();
    HOST.sel();
    wcyc(4);
    check("oe low cs", oe1, 32'h1);
    HOST.shift(8, 32'h15, q);
    HOST.desel();
    check("oe high cs", oe1, 32'h0);
    wcyc(8);
    check("reply", q, 32'h00);
    check("cmd", c1, 32'h15);
    check("out", sw1, 32'h15);
    par = 8'h22;
    wcyc(8);
    check("or", sw1, 32'h37);
    par = 8'h00;
    xfer(16, 32'hC32A);
    check("double reply", q, 32'h00C3);
    check("double cmd", c1, 32'h2A);
    check("double out", sw1, 32'h2A);
  endtask : t_serial

  task automatic t_chain();
    chain = 1'b1;
    xfer(16, 32'h0408);
    check("far cmd", c2, 32'h04);
    check("near cmd", c1, 32'h08);
    xfer(32, 32'h5A0FA11C);
    check("chain reply", q, 32'h00005A0F);
    check("far cmd 32", c2, 32'hA1);
    check("near cmd 32", c1, 32'h1C);
    chain = 1'b0;
  endtask : t_chain

  task automatic t_mode();
    xfer(8, 32'h00);
    mode = 1'b1;
    par = 8'h07;
    wcyc(8);
    check("pairs", sw1, 32'h03);
    xfer(8, 32'h30);
    check("mode reply", q, 32'hFF);
    check("mode cmd", c1, 32'h30);
    check("mode out", sw1, 32'h03);
    chain = 1'b1;
    xfer(16, 32'h0930);
    check("far blocked", c2, 32'hFF);
    check("mode near", c1, 32'h30);
    chain = 1'b0;
    mode = 1'b0;
    par = 8'h00;
    wcyc(8);
    check("mode exit", sw1, 32'h30);
  endtask : t_mode

  task automatic t_short();
    xfer(8, 32'h02);
    clim = 8'h02;
    wcyc(1000);
    check("sense early", {sw1[1], f1[1]}, 32'h2);
    wcyc(1025);
    check("limit off", {sw1[1], f1[1]}, 32'h1);
    wcyc(60);
    check("retry on", sw1[1], 32'h1);
    clim = 8'h00;
    wcyc(2200);
    check("resumed", {sw1[1], f1[1]}, 32'h3);
    xfer(8, 32'h00);
    check("read short", q, 32'h02);
    xfer(8, 32'h00);
    check("read clear", q, 32'h00);
  endtask : t_short

  task automatic t_open();
    HOST.sel();
    odet = 8'h08;
    wcyc(1100);
    check("frozen", f1, 32'h00);
    HOST.shift(8, 32'h00, q);
    HOST.desel();
    wcyc(8);
    check("frozen reply", q, 32'h00);
    check("reopened", f1, 32'h08);
    odet = 8'h00;
    wcyc(8);
    check("held", f1, 32'h08);
    xfer(8, 32'h01);
    check("open reply", q, 32'h08);
    odet = 8'h01;
    wcyc(1100);
    check("on no enable", f1, 32'h00);
    xfer(8, 32'h41);
    wcyc(500);
    check("mask early", f1, 32'h00);
    wcyc(600);
    check("on enabled", f1, 32'h01);
    odet = 8'h00;
    xfer(8, 32'h00);
    xfer(8, 32'h00);
    check("cleared", f1, 32'h00);
  endtask : t_open

  task automatic t_gshort();
    xfer(8, 32'h05);
    par = 8'h40;
    gshort = 1'b1;
    wcyc(8);
    check("shutdown", sw1, 32'h00);
    xfer(8, 32'h0A);
    check("ignored", sw1, 32'h00);
    gshort = 1'b0;
    wcyc(8);
    check("recovered", sw1, 32'h4A);
    par = 8'h00;
  endtask : t_gshort

  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    wcyc(10);
    reset_n = 1'b1;
    wcyc(4);
    t_reset();
    t_serial();
    t_chain();
    t_mode();
    t_short();
    t_open();
    t_gshort();
    wrap_up();
  end
endmodule : lsw_ctrl_tb
`default_nettype wire
